// File: hdl/alternate_function_remap.sv
// alternate-function remap: option byte register, pin routing and peripheral input selection
//
// Overview of operation
// [RL1] bit 7 puts beeper on D4
// [RL2] bit 6 puts two-wire data B5, clock B4
// [RL3] bit 5: trigger B3, complementary outputs B2-B0
// [RL4] bit 4 puts channel four on port D
// [RL5] bit 3 takes break input from D0
// [RL6] bit 2 drives clock output on D0
// [RL7] bits 2 and 3: clock output wins D0
// [RL8] bit 1: third timer A3, second D2
// [RL9] bit 0 takes converter trigger from D3
// [RL10] cleared bit keeps default pin function
// [RL11] software avoids two options on one port
// [RL12] option loaded at reset, routing then static
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
module alternate_function_remap #(
   parameter int OPT_W = remap_pkg::OPT_W
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // option byte from nonvolatile storage
   input wire logic [OPT_W-1:0] nv_option_i,
   output logic nv_prog_o,
   output logic [OPT_W-1:0] nv_prog_data_o,
   // register bus
   input wire logic [remap_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [remap_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [remap_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // pins
   input wire logic [remap_pkg::NUM_PINS-1:0] pin_in_i,
   input wire remap_pkg::pin_drive_t [remap_pkg::NUM_PINS-1:0] dflt_drive_i,
   output remap_pkg::pin_drive_t [remap_pkg::NUM_PINS-1:0] pin_drive_o,
   // peripheral outputs that can be remapped
   input wire logic beeper_i,
   input wire remap_pkg::pin_drive_t twowire_data_i,
   input wire remap_pkg::pin_drive_t twowire_clock_i,
   input wire logic adv_timer_comp_out_a_i,
   input wire logic adv_timer_comp_out_b_i,
   input wire logic adv_timer_comp_out_c_i,
   input wire logic adv_timer_channel_four_i,
   input wire logic configurable_clock_output_i,
   input wire logic third_timer_channel_one_i,
   input wire logic second_timer_channel_three_i,
   // peripheral inputs on their default pins
   input wire logic twowire_data_dflt_i,
   input wire logic twowire_clock_dflt_i,
   input wire logic ext_trigger_dflt_i,
   input wire logic break_dflt_i,
   input wire logic conv_trigger_dflt_i,
   // peripheral inputs after routing
   output logic twowire_data_in_o,
   output logic twowire_clock_in_o,
   output logic adv_timer_ext_trigger_o,
   output logic adv_timer_break_input_o,
   output logic converter_ext_trigger_o
);

   localparam int NP = remap_pkg::NUM_PINS;

   // the bit positions in the package assume an eight-bit option byte
   if (OPT_W != remap_pkg::OPT_W) begin : g_bad_width
      $error("option byte width must be eight bits");
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // option byte registers

   logic [OPT_W-1:0] option_q;
   logic [OPT_W-1:0] option_d;
   logic [OPT_W-1:0] active_q;
   logic [OPT_W-1:0] active_d;
   logic nv_prog_q;
   logic nv_prog_d;
   logic [1:0] shared_q;
   logic [1:0] shared_d;

   // bus decode
   remap_pkg::bus_state_t state_q;
   remap_pkg::bus_state_t state_d;
   logic wait_q;
   logic wait_d;
   logic [remap_pkg::DATA_W-1:0] rdata_q;
   logic [remap_pkg::DATA_W-1:0] rdata_d;
   logic req;
   logic accept;
   logic hit_option;
   logic hit_active;
   logic hit_status;
   logic wr_option;

   assign req = avs_read_i | avs_write_i;
   assign accept = req & (state_q == remap_pkg::BUS_ACK);
   assign hit_option = avs_address_i == remap_pkg::OFF_OPTION;
   assign hit_active = avs_address_i == remap_pkg::OFF_ACTIVE;
   assign hit_status = avs_address_i == remap_pkg::OFF_STATUS;
   assign wr_option = accept & avs_write_i & hit_option & avs_byteenable_i[0];

   // one wait cycle, then a single ack cycle
   assign state_d = (req && state_q == remap_pkg::BUS_IDLE) ? remap_pkg::BUS_ACK
                                                             : remap_pkg::BUS_IDLE;
   assign wait_d = state_d != remap_pkg::BUS_ACK;

   // read mux, unmapped offsets read zero
   assign rdata_d = (hit_option && avs_read_i) ? {{(remap_pkg::DATA_W-OPT_W){1'b0}}, option_q} :
                    (hit_active && avs_read_i) ? {{(remap_pkg::DATA_W-OPT_W){1'b0}}, active_q} :
                    (hit_status && avs_read_i) ? {{(remap_pkg::DATA_W-2){1'b0}}, shared_q} :
                    remap_pkg::DATA_ZERO;

   // a write programs storage; routing follows only after the next reset
   assign option_d = wr_option ? avs_writedata_i[OPT_W-1:0] : option_q;
   assign nv_prog_d = wr_option;
   assign active_d = sys_rst_i ? nv_option_i : active_q; // RL12

   // warn when more than one option touches the same port
   assign shared_d[remap_pkg::STAT_PORT_D_SHARED] =
      ($countones({active_q[remap_pkg::BIT_BEEPER], active_q[remap_pkg::BIT_ADV_CH4],
                   active_q[remap_pkg::BIT_BREAK], active_q[remap_pkg::BIT_CLOCK_OUT],
                   active_q[remap_pkg::BIT_GP_TIMER], active_q[remap_pkg::BIT_CONV_TRIG]}) > 1);
   assign shared_d[remap_pkg::STAT_PORT_B_SHARED] =
      active_q[remap_pkg::BIT_TWOWIRE] & active_q[remap_pkg::BIT_ADV_COMP];

   // routing copy: loaded throughout reset, frozen afterwards
   always_ff @(posedge mclk_i) begin
      active_q <= active_d; // RL12
   end

   // software-visible registers and bus answer
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         option_q <= nv_option_i;
         nv_prog_q <= 1'b0;
         shared_q <= 2'b00;
         state_q <= remap_pkg::BUS_IDLE;
         wait_q <= 1'b1;
         rdata_q <= remap_pkg::DATA_ZERO;
      end else begin
         option_q <= option_d;
         nv_prog_q <= nv_prog_d;
         shared_q <= shared_d;
         state_q <= state_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_waitrequest_o = wait_q;
   assign avs_readdata_o = rdata_q;
   assign nv_prog_o = nv_prog_q;
   assign nv_prog_data_o = option_q;

   //////////////////////////////////////////////////////////////////////////////////////////
   // pin routing

   logic [NP-1:0] remap_sel;
   remap_pkg::pin_drive_t [NP-1:0] remap_drv;
   logic clk_on_d0;
   logic break_on_d0;

   // clock output has priority over the break input on D0
   assign clk_on_d0 = active_q[remap_pkg::BIT_CLOCK_OUT]; // RL6
   assign break_on_d0 = active_q[remap_pkg::BIT_BREAK] & ~clk_on_d0; // RL7

   // which pins leave their default function
   assign remap_sel[remap_pkg::PIN_D4] = active_q[remap_pkg::BIT_BEEPER]; // RL1
   assign remap_sel[remap_pkg::PIN_B5] = active_q[remap_pkg::BIT_TWOWIRE]; // RL2
   assign remap_sel[remap_pkg::PIN_B4] = active_q[remap_pkg::BIT_TWOWIRE]; // RL2
   assign remap_sel[remap_pkg::PIN_B3] = active_q[remap_pkg::BIT_ADV_COMP]; // RL3
   assign remap_sel[remap_pkg::PIN_B2] = active_q[remap_pkg::BIT_ADV_COMP]; // RL3
   assign remap_sel[remap_pkg::PIN_B1] = active_q[remap_pkg::BIT_ADV_COMP]; // RL3
   assign remap_sel[remap_pkg::PIN_B0] = active_q[remap_pkg::BIT_ADV_COMP]; // RL3
   assign remap_sel[remap_pkg::PIN_D_CH4] = active_q[remap_pkg::BIT_ADV_CH4]; // RL4
   assign remap_sel[remap_pkg::PIN_D0] = clk_on_d0 | break_on_d0; // RL5
   assign remap_sel[remap_pkg::PIN_A3] = active_q[remap_pkg::BIT_GP_TIMER]; // RL8
   assign remap_sel[remap_pkg::PIN_D2] = active_q[remap_pkg::BIT_GP_TIMER]; // RL8
   assign remap_sel[remap_pkg::PIN_D3] = active_q[remap_pkg::BIT_CONV_TRIG]; // RL9

   // remapped drive per pin; input-only functions release the pin
   assign remap_drv[remap_pkg::PIN_D4] = '{out: beeper_i, oe: 1'b1};
   assign remap_drv[remap_pkg::PIN_B5] = twowire_data_i;
   assign remap_drv[remap_pkg::PIN_B4] = twowire_clock_i;
   assign remap_drv[remap_pkg::PIN_B3] = remap_pkg::DRIVE_IDLE;
   assign remap_drv[remap_pkg::PIN_B2] = '{out: adv_timer_comp_out_c_i, oe: 1'b1};
   assign remap_drv[remap_pkg::PIN_B1] = '{out: adv_timer_comp_out_b_i, oe: 1'b1};
   assign remap_drv[remap_pkg::PIN_B0] = '{out: adv_timer_comp_out_a_i, oe: 1'b1};
   assign remap_drv[remap_pkg::PIN_D_CH4] = '{out: adv_timer_channel_four_i, oe: 1'b1};
   assign remap_drv[remap_pkg::PIN_D0] = clk_on_d0 ?
      '{out: configurable_clock_output_i, oe: 1'b1} : remap_pkg::DRIVE_IDLE; // RL7
   assign remap_drv[remap_pkg::PIN_A3] = '{out: third_timer_channel_one_i, oe: 1'b1};
   assign remap_drv[remap_pkg::PIN_D2] = '{out: second_timer_channel_three_i, oe: 1'b1};
   assign remap_drv[remap_pkg::PIN_D3] = remap_pkg::DRIVE_IDLE;

   // one registered selector per pin
   for (genvar p = 0; p < NP; p++) begin : g_pin
      pin_route_cell u_cell (
         .mclk_i(mclk_i),
         .sys_rst_i(sys_rst_i),
         .sel_i(remap_sel[p]),
         .remap_i(remap_drv[p]),
         .dflt_i(dflt_drive_i[p]),
         .drive_o(pin_drive_o[p])
      );
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // peripheral input selection

   logic sda_in_q;
   logic scl_in_q;
   logic ext_trig_q;
   logic break_q;
   logic conv_trig_q;

   // each input follows its remapped pin or its default source
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sda_in_q <= 1'b0;
         scl_in_q <= 1'b0;
         ext_trig_q <= 1'b0;
         break_q <= 1'b0;
         conv_trig_q <= 1'b0;
      end else begin
         sda_in_q <= remap_sel[remap_pkg::PIN_B5] ? pin_in_i[remap_pkg::PIN_B5]
                                                  : twowire_data_dflt_i; // RL2
         scl_in_q <= remap_sel[remap_pkg::PIN_B4] ? pin_in_i[remap_pkg::PIN_B4]
                                                  : twowire_clock_dflt_i; // RL2
         ext_trig_q <= remap_sel[remap_pkg::PIN_B3] ? pin_in_i[remap_pkg::PIN_B3]
                                                    : ext_trigger_dflt_i; // RL3
         break_q <= break_on_d0 ? pin_in_i[remap_pkg::PIN_D0] : break_dflt_i; // RL5
         conv_trig_q <= remap_sel[remap_pkg::PIN_D3] ? pin_in_i[remap_pkg::PIN_D3]
                                                     : conv_trigger_dflt_i; // RL9
      end
   end

   assign twowire_data_in_o = sda_in_q;
   assign twowire_clock_in_o = scl_in_q;
   assign adv_timer_ext_trigger_o = ext_trig_q;
   assign adv_timer_break_input_o = break_q;
   assign converter_ext_trigger_o = conv_trig_q;

   //////////////////////////////////////////////////////////////////////////////////////////
   // checks

   property p_beeper;
      @(posedge mclk_i) disable iff (sys_rst_i)
      active_q[remap_pkg::BIT_BEEPER] |=>
         pin_drive_o[remap_pkg::PIN_D4] == {$past(beeper_i), 1'b1};
   endproperty
   a_beeper: assert property (p_beeper) else $error("beeper not on D4"); // RL1

   property p_twowire;
      @(posedge mclk_i) disable iff (sys_rst_i)
      active_q[remap_pkg::BIT_TWOWIRE] |=>
         pin_drive_o[remap_pkg::PIN_B5] == $past(twowire_data_i) &&
         twowire_clock_in_o == $past(pin_in_i[remap_pkg::PIN_B4]);
   endproperty
   a_twowire: assert property (p_twowire) else $error("two-wire not on B5/B4"); // RL2

   property p_adv_comp;
      @(posedge mclk_i) disable iff (sys_rst_i)
      active_q[remap_pkg::BIT_ADV_COMP] |=>
         pin_drive_o[remap_pkg::PIN_B0].out == $past(adv_timer_comp_out_a_i) &&
         pin_drive_o[remap_pkg::PIN_B2].out == $past(adv_timer_comp_out_c_i) &&
         adv_timer_ext_trigger_o == $past(pin_in_i[remap_pkg::PIN_B3]);
   endproperty
   a_adv_comp: assert property (p_adv_comp) else $error("timer set not on port B"); // RL3

   property p_ch4;
      @(posedge mclk_i) disable iff (sys_rst_i)
      active_q[remap_pkg::BIT_ADV_CH4] |=>
         pin_drive_o[remap_pkg::PIN_D_CH4].out == $past(adv_timer_channel_four_i);
   endproperty
   a_ch4: assert property (p_ch4) else $error("channel four not on port D"); // RL4

   property p_break;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (active_q[remap_pkg::BIT_BREAK] && !active_q[remap_pkg::BIT_CLOCK_OUT]) |=>
         adv_timer_break_input_o == $past(pin_in_i[remap_pkg::PIN_D0]) &&
         !pin_drive_o[remap_pkg::PIN_D0].oe;
   endproperty
   a_break: assert property (p_break) else $error("break not taken from D0"); // RL5

   property p_clock_out;
      @(posedge mclk_i) disable iff (sys_rst_i)
      active_q[remap_pkg::BIT_CLOCK_OUT] |=>
         pin_drive_o[remap_pkg::PIN_D0].out == $past(configurable_clock_output_i);
   endproperty
   a_clock_out: assert property (p_clock_out) else $error("clock not on D0"); // RL6

   property p_d0_priority;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (active_q[remap_pkg::BIT_CLOCK_OUT] && active_q[remap_pkg::BIT_BREAK]) |=>
         adv_timer_break_input_o == $past(break_dflt_i) && pin_drive_o[remap_pkg::PIN_D0].oe;
   endproperty
   a_d0_priority: assert property (p_d0_priority) else $error("D0 priority wrong"); // RL7

   property p_gp_timer;
      @(posedge mclk_i) disable iff (sys_rst_i)
      active_q[remap_pkg::BIT_GP_TIMER] |=>
         pin_drive_o[remap_pkg::PIN_A3].out == $past(third_timer_channel_one_i) &&
         pin_drive_o[remap_pkg::PIN_D2].out == $past(second_timer_channel_three_i);
   endproperty
   a_gp_timer: assert property (p_gp_timer) else $error("timer channels not on A3/D2"); // RL8

   property p_conv;
      @(posedge mclk_i) disable iff (sys_rst_i)
      active_q[remap_pkg::BIT_CONV_TRIG] |=>
         converter_ext_trigger_o == $past(pin_in_i[remap_pkg::PIN_D3]);
   endproperty
   a_conv: assert property (p_conv) else $error("trigger not taken from D3"); // RL9

   property p_default;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (!active_q[remap_pkg::BIT_BEEPER] && !active_q[remap_pkg::BIT_CONV_TRIG]) |=>
         pin_drive_o[remap_pkg::PIN_D4] == $past(dflt_drive_i[remap_pkg::PIN_D4]) &&
         converter_ext_trigger_o == $past(conv_trigger_dflt_i);
   endproperty
   a_default: assert property (p_default) else $error("default function lost"); // RL10

   property p_static;
      @(posedge mclk_i) disable iff (sys_rst_i)
      !$past(sys_rst_i) |-> $stable(active_q) ##1 $stable(active_q);
   endproperty
   a_static: assert property (p_static) else $error("routing changed after reset"); // RL12

   property p_bus_ack;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (req && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer not one cycle");

endmodule

// File: hdl/pin_route_cell.sv
// one pin of the remap block: picks remapped or default drive and registers it
module pin_route_cell (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic sel_i,
   input wire remap_pkg::pin_drive_t remap_i,
   input wire remap_pkg::pin_drive_t dflt_i,
   output remap_pkg::pin_drive_t drive_o
);

   remap_pkg::pin_drive_t drive_d;
   remap_pkg::pin_drive_t drive_q;

   // a cleared option leaves the default function on the pin
   assign drive_d = sel_i ? remap_i : dflt_i; // RL10
   assign drive_o = drive_q;

   // pin register, released while in reset
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         drive_q <= remap_pkg::DRIVE_IDLE;
      end else begin
         drive_q <= drive_d;
      end
   end

endmodule

// File: hdl/remap_pkg.sv
// package with register map, option bit positions, pin indices and carriers of the remap block
package remap_pkg;

   // one pin's output value and its output enable
   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_t;

   // width of the option byte and of the register bus
   localparam int OPT_W = 8;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 4;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_OPTION = 4'h0; // pin_remap_option_byte, programs storage
   localparam logic [ADDR_W-1:0] OFF_ACTIVE = 4'h4; // routing in force since reset
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8; // port sharing warnings

   // option bit positions
   localparam int BIT_BEEPER = 7;     // remap_beeper_bit
   localparam int BIT_TWOWIRE = 6;    // remap_twowire_bit
   localparam int BIT_ADV_COMP = 5;   // remap_adv_timer_comp_bit
   localparam int BIT_ADV_CH4 = 4;    // remap_adv_timer_ch4_bit
   localparam int BIT_BREAK = 3;      // remap_timer_break_bit
   localparam int BIT_CLOCK_OUT = 2;  // remap_clock_out_bit
   localparam int BIT_GP_TIMER = 1;   // remap_gp_timer_ch_bit
   localparam int BIT_CONV_TRIG = 0;  // remap_conv_trigger_bit

   // status register fields
   localparam int STAT_PORT_D_SHARED = 0;
   localparam int STAT_PORT_B_SHARED = 1;

   // pin indices of the routed pins
   localparam int NUM_PINS = 12;
   localparam int PIN_D4 = 0;
   localparam int PIN_B5 = 1;
   localparam int PIN_B4 = 2;
   localparam int PIN_B3 = 3;
   localparam int PIN_B2 = 4;
   localparam int PIN_B1 = 5;
   localparam int PIN_B0 = 6;
   localparam int PIN_D_CH4 = 7;
   localparam int PIN_D0 = 8;
   localparam int PIN_A3 = 9;
   localparam int PIN_D2 = 10;
   localparam int PIN_D3 = 11;

   // reset values
   localparam logic [OPT_W-1:0] OPT_CLEAR = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
   localparam pin_drive_t DRIVE_IDLE = '{out: 1'b0, oe: 1'b0};

   // bus answer states, gray along idle -> ack
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } bus_state_t;

endpackage

// File: tb/tb_top.sv
// self-checking bench of the alternate-function remap block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] nv_option_i = 8'h00;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0000_0000;
   logic [3:0] avs_byteenable_i = 4'h0;
   logic [11:0] pin_in_i = 12'h000;
   remap_pkg::pin_drive_t [11:0] dflt_drive_i = '0;
   remap_pkg::pin_drive_t twowire_data_i = '0;
   remap_pkg::pin_drive_t twowire_clock_i = '0;
   logic [7:0] per_out = 8'h00;
   logic [4:0] per_dflt = 5'h00;
   logic nv_prog_o;
   logic [7:0] nv_prog_data_o;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   remap_pkg::pin_drive_t [11:0] pin_drive_o;
   wire [4:0] per_in;
   integer seed = 32'h105c;
   int num_errors = 0;
   int n_compared = 0;

   always #5 mclk_i = ~mclk_i;

   alternate_function_remap uut (
      .mclk_i, .sys_rst_i, .nv_option_i, .nv_prog_o, .nv_prog_data_o,
      .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
      .avs_readdata_o, .avs_waitrequest_o, .pin_in_i, .dflt_drive_i, .pin_drive_o,
      .beeper_i(per_out[7]), .twowire_data_i, .twowire_clock_i,
      .adv_timer_comp_out_a_i(per_out[6]), .adv_timer_comp_out_b_i(per_out[5]),
      .adv_timer_comp_out_c_i(per_out[4]), .adv_timer_channel_four_i(per_out[3]),
      .configurable_clock_output_i(per_out[2]), .third_timer_channel_one_i(per_out[1]),
      .second_timer_channel_three_i(per_out[0]),
      .twowire_data_dflt_i(per_dflt[4]), .twowire_clock_dflt_i(per_dflt[3]),
      .ext_trigger_dflt_i(per_dflt[2]), .break_dflt_i(per_dflt[1]),
      .conv_trigger_dflt_i(per_dflt[0]),
      .twowire_data_in_o(per_in[4]), .twowire_clock_in_o(per_in[3]),
      .adv_timer_ext_trigger_o(per_in[2]), .adv_timer_break_input_o(per_in[1]),
      .converter_ext_trigger_o(per_in[0])
   );

   ////////////////////////////////////////////////////////////////////////////////
   // verdict and comparison
   task finish_test;
      if (num_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // avalon master: hold request until waitrequest is sampled low
   task bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd,
            input logic [3:0] be, output logic [31:0] rd);
      int n;
      avs_address_i <= addr;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      avs_writedata_i <= wd;
      avs_byteenable_i <= be;
      for (n = 0; n < 20; n++) begin
         @(posedge mclk_i);
         if (avs_waitrequest_o === 1'b0) break;
      end
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge mclk_i);
      if (n == 20) begin
         num_errors++;
         finish_test();
      end
   endtask

   task rd_chk(input logic [3:0] addr, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, addr, 32'h0000_0000, 4'hf, r);
      chk(r, exp);
   endtask

   // reset with a given option byte, storage changes right after release
   task do_reset(input logic [7:0] o);
      sys_rst_i <= 1'b1;
      nv_option_i <= o;
      repeat (8) @(posedge mclk_i);
      chk({2'h0, avs_waitrequest_o, pin_drive_o, per_in}, 32'h2000_0000);
      sys_rst_i <= 1'b0;
      nv_option_i <= ~o;
      @(posedge mclk_i);
   endtask

   task rand_inputs;
      logic [31:0] a;
      logic [31:0] b;
      a = $random(seed);
      b = $random(seed);
      pin_in_i <= a[11:0];
      twowire_data_i <= a[13:12];
      twowire_clock_i <= a[15:14];
      per_out <= a[23:16];
      per_dflt <= a[28:24];
      dflt_drive_i <= b[23:0];
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // expected routing; released pins are checked on enable only
   function automatic void exp_route(input logic [7:0] o, output logic [23:0] e,
                                     output logic [23:0] m, output logic [4:0] p);
      e = dflt_drive_i;
      m = 24'hff_ffff;
      if (o[7]) e[2*remap_pkg::PIN_D4 +: 2] = {per_out[7], 1'b1};
      if (o[6]) e[2*remap_pkg::PIN_B5 +: 2] = twowire_data_i;
      if (o[6]) e[2*remap_pkg::PIN_B4 +: 2] = twowire_clock_i;
      if (o[5]) begin
         e[2*remap_pkg::PIN_B3 +: 2] = 2'h0;
         m[2*remap_pkg::PIN_B3 + 1] = 1'b0;
         e[2*remap_pkg::PIN_B2 +: 2] = {per_out[4], 1'b1};
         e[2*remap_pkg::PIN_B1 +: 2] = {per_out[5], 1'b1};
         e[2*remap_pkg::PIN_B0 +: 2] = {per_out[6], 1'b1};
      end
      if (o[4]) e[2*remap_pkg::PIN_D_CH4 +: 2] = {per_out[3], 1'b1};
      if (o[2]) begin
         e[2*remap_pkg::PIN_D0 +: 2] = {per_out[2], 1'b1};
      end else if (o[3]) begin
         e[2*remap_pkg::PIN_D0 +: 2] = 2'h0;
         m[2*remap_pkg::PIN_D0 + 1] = 1'b0;
      end
      if (o[1]) e[2*remap_pkg::PIN_A3 +: 2] = {per_out[1], 1'b1};
      if (o[1]) e[2*remap_pkg::PIN_D2 +: 2] = {per_out[0], 1'b1};
      if (o[0]) begin
         e[2*remap_pkg::PIN_D3 +: 2] = 2'h0;
         m[2*remap_pkg::PIN_D3 + 1] = 1'b0;
      end
      p[4] = o[6] ? pin_in_i[remap_pkg::PIN_B5] : per_dflt[4];
      p[3] = o[6] ? pin_in_i[remap_pkg::PIN_B4] : per_dflt[3];
      p[2] = o[5] ? pin_in_i[remap_pkg::PIN_B3] : per_dflt[2];
      p[1] = (o[3] && !o[2]) ? pin_in_i[remap_pkg::PIN_D0] : per_dflt[1];
      p[0] = o[0] ? pin_in_i[remap_pkg::PIN_D3] : per_dflt[0];
   endfunction

   task check_route(input logic [7:0] o);
      logic [23:0] e;
      logic [23:0] m;
      logic [23:0] pd;
      logic [4:0] p;
      @(posedge mclk_i);
      @(posedge mclk_i);
      exp_route(o, e, m, p);
      pd = pin_drive_o;
      chk({8'h00, pd & m}, {8'h00, e & m});
      chk({27'h000_0000, per_in}, {27'h000_0000, p});
   endtask

   function automatic logic [31:0] status_exp(input logic [7:0] o);
      status_exp = {30'h0000_0000, o[6] & o[5], $countones({o[7], o[4:0]}) > 1};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: corner options, every single bit, then random bytes
   initial begin
      logic [7:0] o;
      logic [7:0] w;
      logic [31:0] r;
      int i;
      int k;
      for (i = 0; i < 20; i++) begin
         if (i < 3) o = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'h0c;
         else if (i < 11) o = 8'h01 << (i - 3);
         else o = 8'($random(seed));
         do_reset(o);
         rd_chk(remap_pkg::OFF_ACTIVE, {24'h00_0000, o});
         rd_chk(remap_pkg::OFF_OPTION, {24'h00_0000, o});
         rd_chk(remap_pkg::OFF_STATUS, status_exp(o));
         for (k = 0; k < 3; k++) begin
            rand_inputs();
            check_route(o);
         end
         w = 8'($random(seed));
         bus(1'b1, remap_pkg::OFF_OPTION, {24'h00_0000, w}, 4'h1, r);
         chk({23'h00_0000, nv_prog_o, nv_prog_data_o}, {24'h00_0001, w});
         @(posedge mclk_i);
         chk({31'h0000_0000, nv_prog_o}, 32'h0000_0000);
         bus(1'b1, remap_pkg::OFF_OPTION, {24'h00_0000, ~w}, 4'h0, r);
         bus(1'b1, remap_pkg::OFF_ACTIVE, {24'h00_0000, ~o}, 4'hf, r);
         rd_chk(remap_pkg::OFF_OPTION, {24'h00_0000, w});
         rd_chk(remap_pkg::OFF_ACTIVE, {24'h00_0000, o});
         rd_chk(4'hc, 32'h0000_0000);
         rand_inputs();
         check_route(o);
      end
      finish_test();
   end

   // watchdog against a hang
   initial begin
      repeat (100000) @(posedge mclk_i);
      num_errors++;
      finish_test();
   end
endmodule
